// *** verilog/frp_pkg.sv ***
package frp_pkg;

  // ==========================================================
  // register bus
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_KEY = 3'h1;
  localparam logic [2:0] REG_ADDR_LOW = 3'h2;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
  localparam logic [2:0] REG_DATA_LOW = 3'h4;
  localparam logic [2:0] REG_DATA_HIGH = 3'h5;
  localparam logic [2:0] REG_IRQ_CTRL = 3'h6;

  // ==========================================================
  // flash_control_reg fields
  localparam int unsigned CTRL_TRIGGER = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_PROGRAM_ENABLE = 2;
  localparam int unsigned CTRL_ERASE_SELECT = 3;
  localparam int unsigned CTRL_LATCH_ONLY = 4;
  localparam int unsigned CTRL_REGION_SELECT = 5;
  localparam int unsigned CTRL_PROGRAM_ERROR = 6;
  localparam int unsigned CTRL_COMPLETION = 7;
  localparam int unsigned IRQ_CTRL_ENABLE = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

  // ==========================================================
  // flash geometry
  localparam int unsigned WORD_W = 14;
  localparam int unsigned NVM_ADDR_W = 15;
  localparam int unsigned ROW_W = 10;
  localparam int unsigned COL_W = 5;
  localparam int unsigned LATCH_COUNT = 32;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  localparam logic [4:0] LAST_COL = 5'h1f;
  localparam logic [14:0] PFM_MAX_ADDR = 15'h3fff;

  // region-select set: offsets inside the id/config space
  localparam logic [14:0] UID_FIRST = 15'h0000;
  localparam logic [14:0] UID_LAST = 15'h0003;
  localparam logic [14:0] DEVID_FIRST = 15'h0005;
  localparam logic [14:0] DEVID_LAST = 15'h0006;
  localparam logic [14:0] CFG_FIRST = 15'h0007;
  localparam logic [14:0] CFG_LAST = 15'h000b;
  localparam logic [14:0] INFO_FIRST = 15'h0100;
  localparam logic [14:0] INFO_LAST = 15'h02ff;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ERASE_TIME_NS = 2000;
  localparam int unsigned PROG_TIME_NS = 2000;
  localparam int unsigned CNT_W = 16;

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned ERASE_CYCLES = ns_to_cycles(ERASE_TIME_NS);
  localparam int unsigned PROG_CYCLES = ns_to_cycles(PROG_TIME_NS);

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    FRP_IDLE = 3'b000,
    FRP_ERASE = 3'b001,
    FRP_WALK = 3'b010,
    FRP_COMMIT = 3'b011,
    FRP_READ = 3'b100
  } frp_state_e;

  typedef enum logic [1:0] {
    FRP_UNLK_IDLE = 2'b00,
    FRP_UNLK_FIRST = 2'b01,
    FRP_UNLK_ARMED = 2'b10
  } frp_unlock_e;

endpackage

// *** verilog/frp_latch_bank.sv ***
module frp_latch_bank (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [frp_pkg::COL_W-1:0] load_idx_i,
  input wire logic [frp_pkg::WORD_W-1:0] load_data_i,
  input wire logic blank_all_i,
  input wire logic [frp_pkg::COL_W-1:0] read_idx_i,
  output logic [frp_pkg::WORD_W-1:0] read_data_o
);
  import frp_pkg::*;

  typedef struct packed {
    logic [LATCH_COUNT-1:0][WORD_W-1:0] words;
  } frp_bank_s;

  frp_bank_s bank_q;
  frp_bank_s bank_d;

  // blanking wins over a load: both never meet, the load happens at trigger time
  always_comb begin
    bank_d = bank_q;
    if (blank_all_i) begin
      for (int i = 0; i < LATCH_COUNT; i++) begin
        bank_d.words[i] = BLANK_WORD;
      end
    end else if (load_i) begin
      bank_d.words[load_idx_i] = load_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_q <= {LATCH_COUNT{BLANK_WORD}};
    end else begin
      bank_q <= bank_d;
    end
  end

  assign read_data_o = bank_q.words[read_idx_i];

endmodule

// *** verilog/frp_sequencer.sv ***
module frp_sequencer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [frp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [frp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [frp_pkg::DATA_W-1:0] reg_rdata_o,
  // system
  input wire logic addr_protected_i,
  input wire logic reset_during_write_i,
  output logic cpu_stall_o,
  output logic completion_irq_o,
  // flash array macro
  output logic flash_region_o,
  output logic [frp_pkg::ROW_W-1:0] flash_row_o,
  output logic [frp_pkg::COL_W-1:0] flash_col_o,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [frp_pkg::WORD_W-1:0] flash_wdata_o,
  output logic flash_commit_o,
  output logic flash_read_o,
  input wire logic [frp_pkg::WORD_W-1:0] flash_rdata_i
);
  import frp_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    frp_state_e st;
    frp_unlock_e unlk;
    logic trigger;
    logic read;
    logic program_enable;
    logic erase_select;
    logic latch_only;
    logic region_select;
    logic program_error_flag;
    logic completion_flag;
    logic completion_irq_enable;
    logic [7:0] flash_addr_low;
    logic [6:0] flash_addr_high;
    logic [7:0] flash_data_low;
    logic [5:0] flash_data_high;
    logic [COL_W-1:0] walk_idx;
    logic [CNT_W-1:0] cnt;
    logic fl_region;
    logic [ROW_W-1:0] fl_row;
    logic [COL_W-1:0] fl_col;
    logic fl_erase;
    logic fl_write;
    logic [WORD_W-1:0] fl_wdata;
    logic fl_commit;
    logic fl_read;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rst_sync;
  } frp_regs_s;

  frp_regs_s q;
  frp_regs_s d;

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [14:0] a, input logic [14:0] lo, input logic [14:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // self-write allowed: program space up to and including the top, or user id / config words
  function automatic logic writable(input logic region, input logic [14:0] a, input logic prot);
    logic ok;
    ok = 1'b0;
    if (!region) begin
      ok = (a <= PFM_MAX_ADDR);
    end else begin
      ok = in_range(a, UID_FIRST, UID_LAST) || in_range(a, CFG_FIRST, CFG_LAST);
    end
    return ok && !prot;
  endfunction

  function automatic logic readable(input logic region, input logic [14:0] a);
    logic ok;
    ok = 1'b0;
    if (!region) begin
      ok = (a <= PFM_MAX_ADDR);
    end else begin
      ok = in_range(a, UID_FIRST, UID_LAST) || in_range(a, DEVID_FIRST, CFG_LAST) ||
           in_range(a, INFO_FIRST, INFO_LAST);
    end
    return ok;
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_image(input frp_regs_s r);
    logic [DATA_W-1:0] v;
    v = CTRL_RESET;
    v[CTRL_TRIGGER] = r.trigger;
    v[CTRL_READ] = r.read;
    v[CTRL_PROGRAM_ENABLE] = r.program_enable;
    v[CTRL_ERASE_SELECT] = r.erase_select;
    v[CTRL_LATCH_ONLY] = r.latch_only;
    v[CTRL_REGION_SELECT] = r.region_select;
    v[CTRL_PROGRAM_ERROR] = r.program_error_flag;
    v[CTRL_COMPLETION] = r.completion_flag;
    return v;
  endfunction

  // ==========================================================
  // latch bank
  logic latch_load;
  logic latch_blank;
  logic [WORD_W-1:0] latch_word;
  logic [NVM_ADDR_W-1:0] nvm_addr;
  logic [WORD_W-1:0] data_pair;

  assign nvm_addr = {q.flash_addr_high, q.flash_addr_low};
  assign data_pair = {q.flash_data_high, q.flash_data_low};

  frp_latch_bank u_latches (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .load_i(latch_load),
    .load_idx_i(nvm_addr[COL_W-1:0]),
    .load_data_i(data_pair),
    .blank_all_i(latch_blank),
    .read_idx_i(q.walk_idx),
    .read_data_o(latch_word)
  );

  // ==========================================================
  // next state
  logic wr_ctrl;
  logic wr_key;
  logic go;

  always_comb begin
    d = q;
    latch_load = 1'b0;
    latch_blank = 1'b0;
    go = 1'b0;
    wr_ctrl = reg_we_i && (reg_addr_i == REG_CTRL);
    wr_key = reg_we_i && (reg_addr_i == REG_KEY);
    d.fl_write = 1'b0;
    d.fl_read = 1'b0;

    // software-visible register writes
    if (wr_ctrl) begin
      d.program_enable = reg_wdata_i[CTRL_PROGRAM_ENABLE];
      d.erase_select = reg_wdata_i[CTRL_ERASE_SELECT];
      d.latch_only = reg_wdata_i[CTRL_LATCH_ONLY];
      d.region_select = reg_wdata_i[CTRL_REGION_SELECT];
      d.program_error_flag = reg_wdata_i[CTRL_PROGRAM_ERROR];
      d.completion_flag = reg_wdata_i[CTRL_COMPLETION];
    end
    if (reg_we_i && (reg_addr_i == REG_ADDR_LOW)) begin
      d.flash_addr_low = reg_wdata_i;
    end
    if (reg_we_i && (reg_addr_i == REG_ADDR_HIGH)) begin
      d.flash_addr_high = reg_wdata_i[6:0];
    end
    if (reg_we_i && (reg_addr_i == REG_DATA_LOW)) begin
      d.flash_data_low = reg_wdata_i;
    end
    if (reg_we_i && (reg_addr_i == REG_DATA_HIGH)) begin
      d.flash_data_high = reg_wdata_i[5:0];
    end
    if (reg_we_i && (reg_addr_i == REG_IRQ_CTRL)) begin
      d.completion_irq_enable = reg_wdata_i[IRQ_CTRL_ENABLE];
    end

    // unlock tracker: any cycle other than the next expected step breaks it, idle cycles included
    unique case (q.unlk)
      FRP_UNLK_IDLE: begin
        if (wr_key && (reg_wdata_i == UNLOCK_KEY_FIRST)) begin
          d.unlk = FRP_UNLK_FIRST;
        end
      end
      FRP_UNLK_FIRST: begin
        if (wr_key && (reg_wdata_i == UNLOCK_KEY_SECOND)) begin
          d.unlk = FRP_UNLK_ARMED;
        end else begin
          d.unlk = FRP_UNLK_IDLE;
          d.program_error_flag = 1'b1;
        end
      end
      FRP_UNLK_ARMED: begin
        d.unlk = FRP_UNLK_IDLE;
        if (wr_ctrl && reg_wdata_i[CTRL_TRIGGER] && reg_wdata_i[CTRL_PROGRAM_ENABLE] && q.st == FRP_IDLE) begin
          go = 1'b1;
        end else begin
          d.program_error_flag = 1'b1;
        end
      end
      default: begin
        d.unlk = FRP_UNLK_IDLE;
      end
    endcase

    unique case (q.st)
      FRP_IDLE: begin
        if (go && reg_wdata_i[CTRL_ERASE_SELECT]) begin
          if (writable(reg_wdata_i[CTRL_REGION_SELECT], nvm_addr, addr_protected_i)) begin
            d.st = FRP_ERASE;
            d.trigger = 1'b1;
            d.cnt = CNT_W'(ERASE_CYCLES - 1);
            d.fl_region = reg_wdata_i[CTRL_REGION_SELECT];
            d.fl_row = nvm_addr[NVM_ADDR_W-1:COL_W];
            d.fl_erase = 1'b1;
          end else begin
            d.trigger = 1'b0;
            d.program_error_flag = 1'b1;
          end
        end else if (go && reg_wdata_i[CTRL_LATCH_ONLY]) begin
          // protection does not apply to the latches, no array access happens
          latch_load = 1'b1;
          d.trigger = 1'b0;
          d.completion_flag = 1'b1;
        end else if (go) begin
          if (writable(reg_wdata_i[CTRL_REGION_SELECT], nvm_addr, addr_protected_i)) begin
            latch_load = 1'b1;
            d.st = FRP_WALK;
            d.trigger = 1'b1;
            d.walk_idx = '0;
            d.fl_region = reg_wdata_i[CTRL_REGION_SELECT];
            d.fl_row = nvm_addr[NVM_ADDR_W-1:COL_W];
          end else begin
            d.trigger = 1'b0;
            d.program_error_flag = 1'b1;
          end
        end else if (wr_ctrl && reg_wdata_i[CTRL_READ]) begin
          d.st = FRP_READ;
          d.read = 1'b1;
          d.fl_region = reg_wdata_i[CTRL_REGION_SELECT];
          d.fl_row = nvm_addr[NVM_ADDR_W-1:COL_W];
          d.fl_col = nvm_addr[COL_W-1:0];
          d.fl_read = 1'b1;
        end
      end
      FRP_ERASE: begin
        // latches and program-enable are not touched here
        if (q.cnt == '0) begin
          d.st = FRP_IDLE;
          d.fl_erase = 1'b0;
          d.trigger = 1'b0;
          d.completion_flag = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      FRP_WALK: begin
        // blank latches are skipped, so a partial row writes only loaded words
        d.fl_write = (latch_word != BLANK_WORD);
        d.fl_wdata = latch_word;
        d.fl_col = q.walk_idx;
        if (q.walk_idx == LAST_COL) begin
          d.st = FRP_COMMIT;
          d.fl_commit = 1'b1;
          d.cnt = CNT_W'(PROG_CYCLES - 1);
        end else begin
          d.walk_idx = q.walk_idx + 1'b1;
        end
      end
      FRP_COMMIT: begin
        if (q.cnt == '0) begin
          d.st = FRP_IDLE;
          d.fl_commit = 1'b0;
          latch_blank = 1'b1;
          d.trigger = 1'b0;
          d.completion_flag = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      FRP_READ: begin
        d.st = FRP_IDLE;
        d.read = 1'b0;
        if (readable(q.fl_region, {q.fl_row, q.fl_col})) begin
          d.flash_data_low = flash_rdata_i[7:0];
          d.flash_data_high = flash_rdata_i[13:8];
        end else begin
          d.flash_data_low = '0;
          d.flash_data_high = '0;
        end
      end
      default: begin
        d.st = FRP_IDLE;
      end
    endcase

    // retained abort marker, seen only after two stages
    d.rst_sync = {q.rst_sync[0], reset_during_write_i};
    if (q.rst_sync[1]) begin
      d.program_error_flag = 1'b1;
    end

    // read data valid for one cycle after the strobe
    d.rdata = '0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_CTRL: d.rdata = ctrl_image(q);
        REG_ADDR_LOW: d.rdata = q.flash_addr_low;
        REG_ADDR_HIGH: d.rdata = {1'b0, q.flash_addr_high};
        REG_DATA_LOW: d.rdata = q.flash_data_low;
        REG_DATA_HIGH: d.rdata = {2'b00, q.flash_data_high};
        REG_IRQ_CTRL: d.rdata = {7'h00, q.completion_irq_enable};
        default: d.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // stall covers the walk and commit too, the cpu may not touch the address meanwhile
  assign cpu_stall_o = (q.st != FRP_IDLE);
  assign completion_irq_o = q.completion_flag && q.completion_irq_enable;
  assign reg_rdata_o = q.rdata;
  assign flash_region_o = q.fl_region;
  assign flash_row_o = q.fl_row;
  assign flash_col_o = q.fl_col;
  assign flash_erase_o = q.fl_erase;
  assign flash_write_o = q.fl_write;
  assign flash_wdata_o = q.fl_wdata;
  assign flash_commit_o = q.fl_commit;
  assign flash_read_o = q.fl_read;

endmodule

// *** tb/frp_sequencer_properties.sv ***
module frp_sequencer_properties
  import frp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic addr_protected_i,
  input wire logic cpu_stall_o,
  input wire logic flash_region_o,
  input wire logic [ROW_W-1:0] flash_row_o,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic [WORD_W-1:0] flash_wdata_o,
  input wire logic flash_commit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================
  // length counters: long holds do not fit a repetition
  logic [CNT_W-1:0] er_cnt_q;
  logic [CNT_W-1:0] cm_cnt_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      er_cnt_q <= '0;
      cm_cnt_q <= '0;
    end else begin
      er_cnt_q <= flash_erase_o ? er_cnt_q + 1'b1 : '0;
      cm_cnt_q <= flash_commit_o ? cm_cnt_q + 1'b1 : '0;
    end
  end
  // ==========================================
  // unlock steps
  sequence s_first;
    reg_we_i && reg_addr_i == REG_KEY && reg_wdata_i == UNLOCK_KEY_FIRST;
  endsequence
  sequence s_second;
    reg_we_i && reg_addr_i == REG_KEY && reg_wdata_i == UNLOCK_KEY_SECOND;
  endsequence
  sequence s_go_latch;
    reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_TRIGGER] && reg_wdata_i[CTRL_PROGRAM_ENABLE]
      && reg_wdata_i[CTRL_LATCH_ONLY] && !reg_wdata_i[CTRL_ERASE_SELECT];
  endsequence
  sequence s_go_erase_prot;
    reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_TRIGGER] && reg_wdata_i[CTRL_PROGRAM_ENABLE]
      && reg_wdata_i[CTRL_ERASE_SELECT] && addr_protected_i;
  endsequence
  // ==========================================
  // properties
  property p_busy_stalls;
    flash_erase_o || flash_commit_o |-> cpu_stall_o;
  endproperty
  a_busy_stalls: assert property (p_busy_stalls) else $error("cpu not stalled while busy");
  property p_release;
    $fell(flash_erase_o) |-> ##[0:2] !cpu_stall_o;
  endproperty
  a_release: assert property (p_release) else $error("cpu held after erase");
  property p_no_auto_erase;
    flash_write_o || flash_commit_o |-> !flash_erase_o;
  endproperty
  a_no_auto_erase: assert property (p_no_auto_erase) else $error("erase during program");
  property p_no_blank_write;
    flash_write_o |-> flash_wdata_o != BLANK_WORD;
  endproperty
  a_no_blank_write: assert property (p_no_blank_write) else $error("blank latch programmed");
  property p_erase_len;
    $fell(flash_erase_o) |-> er_cnt_q == ERASE_CYCLES;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_commit_len;
    $fell(flash_commit_o) |-> cm_cnt_q == PROG_CYCLES;
  endproperty
  a_commit_len: assert property (p_commit_len) else $error("commit length wrong");
  property p_row_hold;
    flash_commit_o |-> $stable(flash_row_o) && $stable(flash_region_o);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row moved during commit");
  property p_latch_only;
    s_first ##1 s_second ##1 s_go_latch |=> (!cpu_stall_o && !flash_write_o && !flash_commit_o)[*3];
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("latch load started flash work");
  property p_protected;
    s_first ##1 s_second ##1 s_go_erase_prot |=> (!flash_erase_o)[*3];
  endproperty
  a_protected: assert property (p_protected) else $error("protected row erased");
  property p_broken;
    s_first ##1 !(reg_we_i && reg_addr_i == REG_KEY && reg_wdata_i == UNLOCK_KEY_SECOND)
      |=> (!flash_erase_o && !flash_write_o)[*2];
  endproperty
  a_broken: assert property (p_broken) else $error("broken unlock started work");
  property p_key_reads_zero;
    reg_re_i && (reg_addr_i == REG_KEY || reg_addr_i == 3'h7) |=> reg_rdata_o == '0;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key or hole read nonzero");
endmodule

bind frp_sequencer frp_sequencer_properties frp_sequencer_properties_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .addr_protected_i(addr_protected_i), .cpu_stall_o(cpu_stall_o),
  .flash_region_o(flash_region_o), .flash_row_o(flash_row_o), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .flash_wdata_o(flash_wdata_o), .flash_commit_o(flash_commit_o));

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic addr_protected_i = 1'b0;
  logic reset_during_write_i = 1'b0;
  logic [WORD_W-1:0] flash_rdata_i = '0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic cpu_stall_o, completion_irq_o, flash_region_o, flash_erase_o, flash_write_o, flash_commit_o;
  logic flash_read_o;
  logic [ROW_W-1:0] flash_row_o;
  logic [COL_W-1:0] flash_col_o;
  logic [WORD_W-1:0] flash_wdata_o;
  int errors = 0;
  int cmp_count = 0;
  logic re_d = 1'b0;
  logic [31:0] rq[$];
  logic [31:0] wq[$];
  logic [31:0] fq[$];
  logic [14:0] base;
  logic [13:0] d;
  int n;

  always #2.5 clk_i = ~clk_i;

  frp_sequencer frp_sequencer_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .addr_protected_i(addr_protected_i), .reset_during_write_i(reset_during_write_i),
    .cpu_stall_o(cpu_stall_o), .completion_irq_o(completion_irq_o), .flash_region_o(flash_region_o),
    .flash_row_o(flash_row_o), .flash_col_o(flash_col_o), .flash_erase_o(flash_erase_o),
    .flash_write_o(flash_write_o), .flash_wdata_o(flash_wdata_o), .flash_commit_o(flash_commit_o),
    .flash_read_o(flash_read_o), .flash_rdata_i(flash_rdata_i));

  // ==========================================
  // checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // results are looked at mid-cycle, where registered outputs have settled
  always @(posedge clk_i) re_d <= reg_re_i;
  always @(negedge clk_i) begin
    if (re_d) begin
      if (rq.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, reg_rdata_o}, rq.pop_front());
    end
    if (flash_write_o === 1'b1) begin
      if (wq.size() == 0) chk(32'h1, 32'h0);
      else chk({13'h0, flash_col_o, flash_wdata_o}, wq.pop_front());
    end
    if (flash_read_o === 1'b1) begin
      if (fq.size() == 0) chk(32'h1, 32'h0);
      else chk({16'h0, flash_region_o, flash_row_o, flash_col_o}, fq.pop_front());
    end
  end
  // ==========================================
  // register bus: strobes stay up between back-to-back calls
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_re_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= v;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    rq.push_back({24'h0, e});
  endtask
  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic unlock(input logic [7:0] c);
    wr(REG_KEY, UNLOCK_KEY_FIRST);
    wr(REG_KEY, UNLOCK_KEY_SECOND);
    wr(REG_CTRL, c);
    idle(2);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (cpu_stall_o !== 1'b0 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    chk(k < 2000, 1);
    idle(1);
  endtask
  task automatic set_addr(input logic [14:0] a);
    wr(REG_ADDR_LOW, a[7:0]);
    wr(REG_ADDR_HIGH, {1'b0, a[14:8]});
  endtask
  task automatic load(input logic [4:0] col, input logic [13:0] v, input logic [7:0] c);
    set_addr(base | 15'(col));
    wr(REG_DATA_LOW, v[7:0]);
    wr(REG_DATA_HIGH, {2'b0, v[13:8]});
    if (v !== BLANK_WORD) wq.push_back({13'h0, col, v});
    unlock(c);
    if (c[CTRL_LATCH_ONLY]) chk(cpu_stall_o, 0);
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(74825));
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    base = {10'($urandom_range(0, 511)), 5'h00};
    load(5'h03, 14'($urandom) & 14'h3ffe, 8'h15);
    unlock(8'h0d);
    chk(flash_erase_o, 1);
    chk(cpu_stall_o, 1);
    chk(flash_row_o, base[14:5]);
    wait_idle();
    rd(REG_CTRL, 8'h8c);
    wr(REG_IRQ_CTRL, 8'h01);
    idle(2);
    chk(completion_irq_o, 1);
    wr(REG_CTRL, 8'h04);
    idle(2);
    chk(completion_irq_o, 0);
    done("erase");
    n = $urandom_range(2, 8);
    for (int i = 4; i < 4 + n; i++) begin
      load(5'(i), 14'($urandom) & 14'h3ffe, 8'h15);
    end
    load(5'h1f, 14'($urandom) & 14'h3ffe, 8'h05);
    chk(flash_row_o, base[14:5]);
    wait_idle();
    chk(wq.size(), 0);
    rd(REG_CTRL, 8'h84);
    load(5'h07, 14'($urandom) & 14'h3ffe, 8'h05);
    wait_idle();
    chk(wq.size(), 0);
    done("program");
    addr_protected_i <= 1'b1;
    unlock(8'h0d);
    chk(flash_erase_o, 0);
    rd(REG_CTRL, 8'h4c);
    addr_protected_i <= 1'b0;
    for (int s = 1; s < 3; s++) begin
      wr(REG_CTRL, 8'h04);
      wr(REG_KEY, UNLOCK_KEY_FIRST);
      if (s == 2) wr(REG_KEY, UNLOCK_KEY_SECOND);
      idle(3);
      chk(cpu_stall_o, 0);
      rd(REG_CTRL, 8'h44);
    end
    wr(REG_CTRL, 8'h04);
    reset_during_write_i <= 1'b1;
    idle(5);
    reset_during_write_i <= 1'b0;
    idle(4);
    rd(REG_CTRL, 8'h44);
    done("errors");
    rd(3'h7, 8'h00);
    rd(REG_KEY, 8'h00);
    d = 14'($urandom);
    flash_rdata_i <= d;
    base = 15'($urandom_range(0, 16'h3fff));
    fq.push_back({17'h0, base});
    set_addr(base);
    wr(REG_CTRL, 8'h02);
    idle(3);
    rd(REG_DATA_LOW, d[7:0]);
    rd(REG_DATA_HIGH, {2'b0, d[13:8]});
    // the last pass hits a readable id word, so zeroing is not the only answer
    for (int j = 0; j < 3; j++) begin
      base = (j == 0) ? 15'h0004 : (j == 1) ? 15'h0300 : DEVID_FIRST;
      fq.push_back({17'h1, base});
      set_addr(base);
      wr(REG_CTRL, 8'h22);
      idle(3);
      rd(REG_DATA_LOW, (j == 2) ? d[7:0] : 8'h00);
      rd(REG_DATA_HIGH, (j == 2) ? {2'b0, d[13:8]} : 8'h00);
    end
    idle(3);
    chk(fq.size(), 0);
    done("reads");
    tally_and_finish();
  end

  // whole run needs some 1500 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
endmodule
